// ### design/rco_defines.svh
// Register offsets, field positions, reset values for the reference clock output
`ifndef RCO_DEFINES_SVH
`define RCO_DEFINES_SVH
`define RCO_CONTROL_IDX      12'h100
`define RCO_SOURCE_IDX       12'h101
`define RCO_CONTROL_ADDR     14'h0400
`define RCO_SOURCE_ADDR      14'h0404
`define RCO_STATUS_ADDR      14'h0408
`define RCO_EN_BIT           7
`define RCO_DUTY_HI          4
`define RCO_DUTY_LO          3
`define RCO_DIV_HI           2
`define RCO_DIV_LO           0
`define RCO_CONTROL_RESET    8'h10
`define RCO_SOURCE_RESET     4'h0
`define RCO_CONTROL_MASK     8'h9F
`endif

// ### design/rco_pkg.sv
// Types for the reference clock output
package rco_pkg;
  typedef enum logic [3:0]
  {
    RCO_SRC_SYS      = 4'h0,
    RCO_SRC_HIGH     = 4'h1,
    RCO_SRC_LOW      = 4'h2,
    RCO_SRC_MID500   = 4'h3,
    RCO_SRC_MID32    = 4'h4,
    RCO_SRC_SEC      = 4'h5,
    RCO_SRC_EXT      = 4'h6,
    RCO_SRC_LC1      = 4'h7,
    RCO_SRC_LC2      = 4'h8,
    RCO_SRC_LC3      = 4'h9,
    RCO_SRC_LC4      = 4'hA
  } rco_src_t;
  typedef enum logic [1:0]
  {
    RCO_DUTY_0  = 2'h0,
    RCO_DUTY_25 = 2'h1,
    RCO_DUTY_50 = 2'h2,
    RCO_DUTY_75 = 2'h3
  } rco_duty_t;
endpackage

// ### design/rco_top.sv
// Reference clock output: source select, power-of-two divider, duty shaping
//
// Functional notes
// - Output starts glitch free: on enable the first period begins cleanly from a low output, the count parked at period_m1 so the first tick wraps it to zero.
// - Clearing enable forces the output low at once, mid period or not.
// - The divider field divides the source by two to the field value, 1 up to 128; the system oscillator at field zero is divided by 2.
// - With divider 2 or more the duty field gives 75, 50, 25 or 0 percent high time; at divider 1, 75 gives 50 and 25 gives 0.
// - With divider zero the output runs at 50 percent on the system oscillator and follows the source level on other sources, for any nonzero duty.
// - Duty 00 holds the output low for every divider.
// - The duty field resets to 10.
// - In sleep the block keeps running for every source except the system oscillator.
// - The source field picks system, high, low, mid 500k, mid 32k, secondary, external, logic cells 1 to 4.
// - Bit 7 of the control register enables the block.
// - The divided clock is also offered to internal peripherals.
//
// Implementation choice: register access over Wishbone.
`include "rco_defines.svh"
module rco_top
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        sleep_mode,
  input  wire logic        internal_high_osc,
  input  wire logic        internal_low_osc,
  input  wire logic        internal_mid_osc,
  input  wire logic        internal_mid_osc_32k,
  input  wire logic        secondary_osc,
  input  wire logic        external_osc,
  input  wire logic        logic_cell_1_output,
  input  wire logic        logic_cell_2_output,
  input  wire logic        logic_cell_3_output,
  input  wire logic        logic_cell_4_output,
  output logic             ref_output,
  output logic             ref_internal
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  // Ack and err are registered: every request is answered one cycle after it is taken
  logic [7:0] control_reg;
  logic [3:0] source_reg;
  logic       ack_reg;
  logic       err_reg;
  logic [31:0] rdata_reg;

  wire        bus_req     = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
  wire        hit_control = (wb_adr_i[13:0] == `RCO_CONTROL_ADDR) & (wb_adr_i[31:14] == 18'h00000);
  wire        hit_source  = (wb_adr_i[13:0] == `RCO_SOURCE_ADDR) & (wb_adr_i[31:14] == 18'h00000);
  wire        hit_status  = (wb_adr_i[13:0] == `RCO_STATUS_ADDR) & (wb_adr_i[31:14] == 18'h00000);
  wire        hit_any     = hit_control | hit_source | hit_status;
  wire        wr_lane0    = bus_req & wb_we_i & wb_sel_i[0];
  wire        enable      = control_reg[`RCO_EN_BIT];
  wire [1:0]  duty_select = control_reg[`RCO_DUTY_HI:`RCO_DUTY_LO];
  wire [2:0]  div_sel     = control_reg[`RCO_DIV_HI:`RCO_DIV_LO];
  logic       out_reg;
  logic       running_reg;
  wire [31:0] rdata_next  = hit_control ? {24'h000000, control_reg} :
                            hit_source  ? {28'h0000000, source_reg} :
                            hit_status  ? {30'h00000000, running_reg, out_reg} : 32'h00000000;

  // Live changes of divider or duty are accepted as written
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      control_reg <= `RCO_CONTROL_RESET;
      source_reg  <= `RCO_SOURCE_RESET;
    end
    else
    begin
      if (wr_lane0 & hit_control)
        control_reg <= wb_dat_i[7:0] & `RCO_CONTROL_MASK;
      if (wr_lane0 & hit_source)
        source_reg <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg   <= bus_req & hit_any;
      err_reg   <= bus_req & ~hit_any;
      rdata_reg <= (bus_req & ~wb_we_i) ? rdata_next : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection, two-flop synchronisers
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic       src_prev_reg;
  wire  [9:0] raw_src = {logic_cell_4_output, logic_cell_3_output, logic_cell_2_output, logic_cell_1_output,
                         external_osc, secondary_osc, internal_mid_osc_32k, internal_mid_osc,
                         internal_low_osc, internal_high_osc};
  logic       sleep_s1_reg;
  logic       sleep_s2_reg;

  // Sources must stay below half of clk_sys, or edges are lost between samples
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= 10'h000;
      sync2_reg <= 10'h000;
    end
    else
    begin
      sync1_reg <= raw_src;
      sync2_reg <= sync1_reg;
    end
  end

  // Sleep level from the pin, two flops before use
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
    end
    else
    begin
      sleep_s1_reg <= sleep_mode;
      sleep_s2_reg <= sleep_s1_reg;
    end
  end

  // System oscillator source: one tick per clk_sys cycle, halted in sleep
  logic src_level;
  logic src_tick;
  always_comb
  begin
    src_level = 1'b0;
    src_tick  = 1'b0;
    case (rco_pkg::rco_src_t'(source_reg))
      rco_pkg::RCO_SRC_SYS:
      begin
        src_tick = ~sleep_s2_reg;
      end
      rco_pkg::RCO_SRC_HIGH,
      rco_pkg::RCO_SRC_LOW,
      rco_pkg::RCO_SRC_MID500,
      rco_pkg::RCO_SRC_MID32,
      rco_pkg::RCO_SRC_SEC,
      rco_pkg::RCO_SRC_EXT,
      rco_pkg::RCO_SRC_LC1,
      rco_pkg::RCO_SRC_LC2,
      rco_pkg::RCO_SRC_LC3,
      rco_pkg::RCO_SRC_LC4:
      begin
        src_level = sync2_reg[source_reg - 4'h1];
        src_tick  = src_level & ~src_prev_reg;
      end
      default:
      begin
        src_tick = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      src_prev_reg <= 1'b0;
    else
      src_prev_reg <= src_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider and duty shaping in source-edge units
  // Count runs 0 to period_m1, one step per source tick; the undivided case bypasses it
  logic [7:0] cnt_reg;
  wire  [7:0] period_m1 = (8'h01 << div_sel) - 8'h01;
  wire  [7:0] cnt_next  = (cnt_reg >= period_m1) ? 8'h00 : cnt_reg + 8'h01;
  wire  [8:0] period_len = {1'b0, period_m1} + 9'h001;
  logic [8:0] high_len;
  always_comb
  begin
    case (rco_pkg::rco_duty_t'(duty_select))
      rco_pkg::RCO_DUTY_25: high_len = period_len >> 2;
      rco_pkg::RCO_DUTY_50: high_len = period_len >> 1;
      rco_pkg::RCO_DUTY_75: high_len = (period_len >> 1) + (period_len >> 2);
      default:              high_len = 9'h000;
    endcase
  end
  wire        undivided    = (div_sel == 3'h0);
  wire        duty_on      = (duty_select != 2'h0);
  wire        src_is_sys   = (source_reg == 4'h0);
  wire        src_reserved = (source_reg > 4'hA);
  // Forced low rather than frozen: a stuck high level reads as a live clock downstream
  wire        force_low    = src_reserved | ~duty_on;
  // Undivided: toggle each source edge, giving half the rate at 50% would be wrong, so a
  // source tick sets high and the following clk_sys cycle clears, giving 50% on sys source
  wire        level_div  = ({1'b0, cnt_next} < high_len);
  wire        undiv_next = duty_on & (src_is_sys ? (src_tick & ~out_reg) : src_level);
  wire        out_next   = undivided ? undiv_next : level_div;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg     <= 8'h00;
      out_reg     <= 1'b0;
      running_reg <= 1'b0;
    end
    else if (!enable)
    begin
      cnt_reg     <= period_m1;
      out_reg     <= 1'b0;
      running_reg <= 1'b0;
    end
    else
    begin
      running_reg <= 1'b1;
      if (src_tick)
        cnt_reg <= cnt_next;
      if (force_low)
        out_reg <= 1'b0;
      else if (undivided | src_tick)
        out_reg <= out_next;
    end
  end

  // Pin and internal copy from one flop each
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ref_output   <= 1'b0;
      ref_internal <= 1'b0;
    end
    else
    begin
      ref_output   <= out_reg & enable;
      ref_internal <= out_reg & enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_disable_low: assert property (@(posedge clk_sys) disable iff (!nrst)
    !enable |=> !ref_output) else $error("output not low after disable");
  chk_duty_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    (duty_select == 2'h0) |=> !out_reg) else $error("duty zero not low");
  chk_reserved_src: assert property (@(posedge clk_sys) disable iff (!nrst)
    src_reserved |=> !out_reg)
    else $error("reserved source drove output");
  chk_reset_duty: assert property (@(posedge clk_sys)
    $rose(nrst) |-> duty_select == 2'h2) else $error("duty reset wrong");
  chk_start_clean: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(enable) |-> !out_reg) else $error("enable started high");
  chk_enable_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
    ref_output |-> $past(enable)) else $error("output without enable");
  chk_sleep_sys: assert property (@(posedge clk_sys) disable iff (!nrst)
    sleep_s2_reg && source_reg == 4'h0 |-> !src_tick) else $error("sys source ran in sleep");
  chk_count_range: assert property (@(posedge clk_sys) disable iff (!nrst)
    enable && $stable(div_sel) && $past(enable) |-> cnt_reg <= period_m1) else $error("count past period");
  chk_internal_copy: assert property (@(posedge clk_sys) disable iff (!nrst)
    ref_internal == ref_output) else $error("internal copy differs");
  chk_undiv_toggle: assert property (@(posedge clk_sys) disable iff (!nrst)
    enable && undivided && duty_on && src_is_sys && !sleep_s2_reg |=> out_reg != $past(out_reg))
    else $error("undivided output not toggling");
  chk_undiv_follow: assert property (@(posedge clk_sys) disable iff (!nrst)
    enable && undivided && duty_on && !src_is_sys && !src_reserved |=> out_reg == $past(src_level))
    else $error("undivided output not following source");
  chk_duty_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
    (duty_select == 2'h0) |-> ##2 !ref_output) else $error("duty zero reached pin");
  chk_reserved_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
    src_reserved |-> ##2 !ref_output) else $error("reserved source reached pin");
  chk_div_wrap: assert property (@(posedge clk_sys) disable iff (!nrst)
    enable && !undivided && src_tick && (cnt_reg == period_m1) |=> cnt_reg == 8'h00)
    else $error("divider did not wrap");
  chk_cnt_start: assert property (@(posedge clk_sys) disable iff (!nrst)
    !enable |=> cnt_reg == $past(period_m1)) else $error("count not parked while disabled");
  chk_running_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
    enable |=> running_reg) else $error("running flag not set");
  chk_sleep_other: assert property (@(posedge clk_sys) disable iff (!nrst)
    sleep_s2_reg && !src_is_sys && !src_reserved && src_level && !src_prev_reg |-> src_tick)
    else $error("sleep stopped a running source");
  cov_enable: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(ref_output));
  cov_div128: cover property (@(posedge clk_sys) disable iff (!nrst) enable && div_sel == 3'h7 && src_tick);
  cov_duty75: cover property (@(posedge clk_sys) disable iff (!nrst) ref_output && duty_select == 2'h3);
  cov_sleep: cover property (@(posedge clk_sys) disable iff (!nrst) sleep_s2_reg && ref_output);
  cov_undiv: cover property (@(posedge clk_sys) disable iff (!nrst) enable && undivided && src_is_sys && ref_output);

endmodule

// ### verif/rco_osc_model.sv
// Oscillator bank standing in for the clock sources outside the block
module rco_osc_model
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  output logic      [10:1] osc
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [10:1];
  // Source k toggles every 4k cycles, kept well under clk_sys/2
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= '{default: 0};
      osc <= '0;
    end
    else
    begin
      for (int k = 1; k <= 10; k++)
      begin
        cnt[k] <= (cnt[k] == 4 * k - 1) ? 0 : cnt[k] + 1;
        if (cnt[k] == 4 * k - 1)
          osc[k] <= ~osc[k];
      end
    end
  end
endmodule

// ### verif/reference_clock_output_test.sv
// Bus driven tests of the reference clock output
module reference_clock_output_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, nrst, cyc, stb, we, sleep_mode, ack, err, ref_output, ref_internal, prev, e;
  logic [31:0] adr, wdat, rdat, q;
  logic [3:0]  sel;
  logic [10:1] osc;
  int          n_mismatch, check_count, hi, ri;
  // Divider, duty, high cycles and rising edges per 1024 cycles
  int          cd [9] = '{7, 2, 3, 0, 0, 5, 0, 4, 6};
  int          cy [9] = '{3, 1, 2, 2, 1, 0, 0, 2, 1};
  int          ch [9] = '{768, 256, 512, 512, 512, 0, 0, 512, 256};
  int          cr [9] = '{8, 256, 128, 512, 512, 0, 0, 64, 16};

  rco_osc_model osc_u (.clk_sys(clk_sys), .nrst(nrst), .osc(osc));
  rco_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack), .wb_err_o(err),
    .sleep_mode(sleep_mode), .internal_high_osc(osc[1]), .internal_low_osc(osc[2]),
    .internal_mid_osc(osc[3]), .internal_mid_osc_32k(osc[4]), .secondary_osc(osc[5]),
    .external_osc(osc[6]), .logic_cell_1_output(osc[7]), .logic_cell_2_output(osc[8]),
    .logic_cell_3_output(osc[9]), .logic_cell_4_output(osc[10]), .ref_output(ref_output),
    .ref_internal(ref_internal));

  ////////////////////////////////////////////////////////////////////////////
  task fail(input string m);
    n_mismatch++;
    $display("Error %0t: %s", $time, m);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
      fail($sformatf("got %h expected %h", got, exp));
  endtask

  task near(input int got, input int exp);
    check_count++;
    if (got < exp - 1 || got > exp + 1)
      fail($sformatf("edge count %0d expected %0d", got, exp));
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    sel  <= s;
    do
      @(posedge clk_sys);
    while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task meas;
    hi = 0;
    ri = 0;
    prev = ref_output;
    repeat (1024)
    begin
      @(posedge clk_sys);
      hi += (ref_output === 1'b1);
      ri += (ref_output === 1'b1 && prev !== 1'b1);
      chk(ref_internal, ref_output);
      prev = ref_output;
    end
  endtask

  // Fields settle while disabled, so no glitch is expected
  task run(input logic [3:0] src, input logic [7:0] ctl);
    bus(1'b1, 32'h00000404, {4'h0, src}, 4'hF);
    bus(1'b1, 32'h00000400, ctl, 4'hF);
    bus(1'b1, 32'h00000400, ctl | 8'h80, 4'hF);
    repeat (300) @(posedge clk_sys);
    meas;
    bus(1'b1, 32'h00000400, ctl, 4'hF);
  endtask

  task wait_lvl(input logic v);
    int n;
    n = 0;
    while (ref_output !== v && n < 600)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 600)
      fail("output stuck");
  endtask

  task report_and_stop;
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    #600us;
    fail("watchdog");
    report_and_stop;
  end

  initial
  begin
    {nrst, cyc, stb, we, sleep_mode, adr, wdat, sel} <= '0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    bus(1'b0, 32'h00000400, 8'h00, 4'hF);
    chk(q, 32'h00000010);
    bus(1'b0, 32'h00000404, 8'h00, 4'hF);
    chk(q, 32'h00000000);
    bus(1'b1, 32'h00000404, 8'hFF, 4'hF);
    bus(1'b0, 32'h00000404, 8'h00, 4'hF);
    chk(q, 32'h0000000F);
    bus(1'b1, 32'h00000400, 8'h7F, 4'hE);
    bus(1'b0, 32'h00000400, 8'h00, 4'hF);
    chk(q, 32'h00000010);
    bus(1'b1, 32'h00000400, 8'h7F, 4'hF);
    bus(1'b0, 32'h00000400, 8'h00, 4'hF);
    chk(q, 32'h0000001F);
    bus(1'b0, 32'h0000040C, 8'h00, 4'hF);
    chk(e, 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      run(4'h0, 8'(cy[i] * 8 + cd[i]));
      chk(hi, ch[i]);
      chk(ri, cr[i]);
    end
    for (int k = 1; k <= 10; k++)
    begin
      run(4'(k), 8'h10);
      near(ri, 128 / k);
    end
    run(4'h1, 8'h11);
    chk(hi, 512);
    chk(ri, 64);
    run(4'hB, 8'h1F);
    chk(hi, 0);
    sleep_mode <= 1'b1;
    run(4'h0, 8'h10);
    chk(ri, 0);
    run(4'h1, 8'h10);
    near(ri, 128);
    sleep_mode <= 1'b0;
    run(4'h0, 8'h17);
    bus(1'b1, 32'h00000400, 8'h97, 4'hF);
    wait_lvl(1'b1);
    hi = 0;
    while (ref_output === 1'b1 && hi < 600)
    begin
      @(posedge clk_sys);
      hi++;
    end
    chk(hi, 64);
    wait_lvl(1'b1);
    repeat (10) @(posedge clk_sys);
    bus(1'b1, 32'h00000400, 8'h17, 4'hF);
    repeat (1) @(posedge clk_sys);
    chk(ref_output, 1'b0);
    bus(1'b1, 32'h00000400, 8'h97, 4'hF);
    wait_lvl(1'b1);
    bus(1'b1, 32'h00000404, 8'h0B, 4'hF);
    repeat (2) @(posedge clk_sys);
    chk(ref_output, 1'b0);
    bus(1'b0, 32'h00000408, 8'h00, 4'hF);
    chk(q, 32'h00000002);
    bus(1'b1, 32'h00000400, 8'h17, 4'hF);
    report_and_stop;
  end
endmodule
